// >>> dpot_defines.svh
// Constants shared by the dual potentiometer serial control block.
`ifndef DPOT_DEFINES_SVH
`define DPOT_DEFINES_SVH

// ----------------------------------------------------------------------
// Register geometry
// ----------------------------------------------------------------------
`define DP_WIPER_W 6
`define DP_TAPS 64
`define DP_CHANNELS 2
`define DP_SLOTS 4
`define DP_WIPER_MAX 6'h3F
`define DP_WIPER_MIN 6'h00
`define DP_PRESET_INIT 6'h20

// ----------------------------------------------------------------------
// Slave address byte: fixed upper nibble, strap nibble below it
// ----------------------------------------------------------------------
`define DP_SLAVE_ID 4'h5

// ----------------------------------------------------------------------
// Instruction byte: op [7:4], preset slot [3:2], channel [0]
// ----------------------------------------------------------------------
`define DP_OP_INCDEC 4'h2
`define DP_OP_RD_WIPER 4'h9
`define DP_OP_WR_WIPER 4'hA
`define DP_OP_RD_PRESET 4'hB
`define DP_OP_WR_PRESET 4'hC
`define DP_OP_RECALL 4'hD
`define DP_OP_STORE 4'hE
`define DP_BIT_ACK 4'h8

`endif

// >>> dpot_pkg.sv
// Types shared by the dual potentiometer serial control block.
package dpot_pkg;
`include "dpot_defines.svh"

    // Byte-level phase of a serial transfer.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_INSTR,
        ST_WDATA,
        ST_RDATA
    } phase_t;

    // Line events seen by the system clock, one cycle each.
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } bus_evt_t;

    // One-hot tap selection for both channels.
    typedef struct packed {
        logic [`DP_TAPS-1:0] tap1;
        logic [`DP_TAPS-1:0] tap0;
    } wiper_taps_t;
endpackage

// >>> dual_digipot_serial_control.sv
// Serial slave and register file of the dual digital potentiometer.
//
// Behaviour
// - Each channel holds a 6-bit wiper position.
// - Four non-volatile 6-bit presets per channel.
// - Reset copies preset zero into each wiper.
// - Guard low refuses preset writes, not wiper.
// - Guard high or open allows all writes.
// - Answer only when address matches the straps.
// - Data line only pulled low or released.
// - Serial clock alone paces every transfer.
// - Exactly one tap selected per channel.
// - Master reads and writes wiper and presets.
// - Copy between wiper and presets both ways.
// - Increment/decrement mode steps the wiper.
`timescale 1ns/1ps
module dual_digipot_serial_control (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out_out,
    output logic sda_oe_out,
    input wire logic [3:0] addr_strap_in,
    input wire logic write_guard_n_in,
    output dpot_pkg::wiper_taps_t taps_out
);
`include "dpot_defines.svh"

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Saturating one-tap step up or down.
    function automatic logic [5:0] step(input logic [5:0] w,
                                        input logic up);
        if (up) begin
            step = (w == `DP_WIPER_MAX) ? w : w + 6'h01;
        end else begin
            step = (w == `DP_WIPER_MIN) ? w : w - 6'h01;
        end
    endfunction

    // One-hot tap decode of a wiper position.
    function automatic logic [63:0] onehot(input logic [5:0] w);
        onehot = 64'h1 << w;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    dpot_pkg::bus_evt_t evt; // Line events from the front end.
    dpot_pkg::phase_t phase_q; // Byte phase of the transfer.
    logic [3:0] cnt_q; // Bits received in the current byte.
    logic ack_q; // High during the ninth clock slot.
    logic ack_mine_q; // This device owns the current ack slot.
    logic [7:0] shreg_q; // Incoming byte.
    logic [7:0] tx_q; // Outgoing byte.
    logic [3:0] op_q; // Latched instruction code.
    logic [1:0] slot_q; // Latched preset slot.
    logic ch_q; // Latched channel.
    logic [5:0] wiper_q [2]; // Live wiper positions.
    logic [5:0] preset_q [2][4] = '{default: `DP_PRESET_INIT};
    logic [3:0] strap_m_q; // Strap synchroniser first stage.
    logic [3:0] strap_q; // Settled straps.
    logic guard_m_q; // Guard synchroniser first stage.
    logic guard_q; // Settled guard level.
    logic byte_end; // Eighth bit done, ack slot begins.
    logic ack_end; // Ack slot done.
    logic addr_hit; // Address byte matches this device.
    logic protect; // Preset writes refused.
    logic wip_we; // Load a wiper this cycle.
    logic [5:0] wip_val; // Value for that load.
    logic pre_we; // Store a preset this cycle.
    logic pre_try; // A preset store was asked for.
    logic [5:0] pre_val; // Value for that store.
    logic do_ack; // Pull the line low in the ack slot.
    logic [7:0] rd_byte; // Byte a read instruction returns.

    serial_line_sense u_sense (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .evt_out(evt)
    );

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Straps and guard are pins, so each passes two flops.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            strap_m_q <= 4'h0;
            strap_q <= 4'h0;
            guard_m_q <= 1'b1;
            guard_q <= 1'b1;
        end else begin
            strap_m_q <= addr_strap_in;
            strap_q <= strap_m_q;
            guard_m_q <= write_guard_n_in;
            guard_q <= guard_m_q;
        end
    end

    // ------------------------------------------------------------------
    // Byte decode
    // ------------------------------------------------------------------
    // Works out what the byte just received asks the registers to do.
    always_comb begin
        byte_end = evt.scl_fall & ~ack_q & (cnt_q == `DP_BIT_ACK);
        ack_end = evt.scl_fall & ack_q;
        addr_hit = (shreg_q == {`DP_SLAVE_ID, strap_q});
        protect = ~guard_q;
        wip_we = 1'b0;
        wip_val = wiper_q[ch_q];
        pre_try = 1'b0;
        pre_val = wiper_q[ch_q];
        do_ack = 1'b0;
        rd_byte = 8'h00;
        if (phase_q == dpot_pkg::ST_RDATA) begin
            do_ack = 1'b0;
        end else if (phase_q == dpot_pkg::ST_ADDR) begin
            do_ack = addr_hit;
        end else if (phase_q == dpot_pkg::ST_INSTR) begin
            do_ack = 1'b1;
            if (shreg_q[7:4] == `DP_OP_RECALL) begin
                wip_we = 1'b1;
                wip_val = preset_q[shreg_q[0]][shreg_q[3:2]];
            end else if (shreg_q[7:4] == `DP_OP_STORE) begin
                pre_try = 1'b1;
                pre_val = wiper_q[shreg_q[0]];
                do_ack = ~protect;
            end else if (shreg_q[7:4] == `DP_OP_RD_WIPER) begin
                rd_byte = {2'h0, wiper_q[shreg_q[0]]};
            end else if (shreg_q[7:4] == `DP_OP_RD_PRESET) begin
                rd_byte = {2'h0, preset_q[shreg_q[0]][shreg_q[3:2]]};
            end
        end else if (phase_q == dpot_pkg::ST_WDATA) begin
            do_ack = 1'b1;
            if (op_q == `DP_OP_WR_WIPER) begin
                wip_we = 1'b1;
                wip_val = shreg_q[5:0];
            end else if (op_q == `DP_OP_INCDEC) begin
                wip_we = 1'b1;
                wip_val = step(wiper_q[ch_q], shreg_q[7]);
            end else if (op_q == `DP_OP_WR_PRESET) begin
                pre_try = 1'b1;
                pre_val = shreg_q[5:0];
                do_ack = ~protect;
            end
        end
        wip_we = wip_we & byte_end;
        pre_try = pre_try & byte_end;
        pre_we = pre_try & ~protect;
    end

    // ------------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------------
    // Counts bits on clock rises, acts and drives data on clock falls.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in || evt.stop) begin
            phase_q <= dpot_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
            ack_mine_q <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (evt.start) begin
            phase_q <= dpot_pkg::ST_ADDR;
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (evt.scl_rise) begin
            if (!ack_q && cnt_q != `DP_BIT_ACK) begin
                shreg_q <= {shreg_q[6:0], evt.sda};
                cnt_q <= cnt_q + 4'h1;
            end else if (ack_q && !ack_mine_q && evt.sda) begin
                phase_q <= dpot_pkg::ST_IDLE;
            end
        end else if (byte_end) begin
            ack_q <= 1'b1;
            ack_mine_q <= do_ack;
            sda_oe_out <= do_ack;
            if (phase_q == dpot_pkg::ST_ADDR) begin
                phase_q <= addr_hit ? dpot_pkg::ST_INSTR
                                    : dpot_pkg::ST_IDLE;
            end else if (phase_q == dpot_pkg::ST_INSTR) begin
                op_q <= shreg_q[7:4];
                slot_q <= shreg_q[3:2];
                ch_q <= shreg_q[0];
                tx_q <= rd_byte;
                if (shreg_q[7:4] == `DP_OP_RD_WIPER ||
                    shreg_q[7:4] == `DP_OP_RD_PRESET) begin
                    phase_q <= dpot_pkg::ST_RDATA;
                end else begin
                    phase_q <= dpot_pkg::ST_WDATA;
                end
            end
        end else if (ack_end) begin
            ack_q <= 1'b0;
            cnt_q <= 4'h0;
            sda_oe_out <= (phase_q == dpot_pkg::ST_RDATA) & ~tx_q[7];
        end else if (evt.scl_fall && phase_q == dpot_pkg::ST_RDATA &&
                     !ack_q && cnt_q != 4'h0) begin
            sda_oe_out <= ~tx_q[3'h7 - cnt_q[2:0]];
        end
    end

    // ------------------------------------------------------------------
    // Wiper registers and tap outputs
    // ------------------------------------------------------------------
    // Reset recalls preset zero; otherwise loads follow the decode.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            wiper_q[0] <= preset_q[0][0];
            wiper_q[1] <= preset_q[1][0];
        end else if (wip_we) begin
            wiper_q[ch_eff()] <= wip_val;
        end
    end

    // Channel for a load: instruction bytes name it directly.
    function automatic logic ch_eff();
        ch_eff = (phase_q == dpot_pkg::ST_INSTR) ? shreg_q[0] : ch_q;
    endfunction

    // Each tap bus is a one-hot copy of its wiper.
    always_ff @(posedge clock_in) begin
        taps_out.tap0 <= onehot(wiper_q[0]);
        taps_out.tap1 <= onehot(wiper_q[1]);
        sda_out_out <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Non-volatile presets
    // ------------------------------------------------------------------
    // No reset: the contents survive power cycles and resets.
    always_ff @(posedge clock_in) begin
        if (pre_we) begin
            preset_q[ch_eff()][(phase_q == dpot_pkg::ST_INSTR)
                ? shreg_q[3:2] : slot_q] <= pre_val;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_recall_reset: assert property (@(posedge clock_in)
        sys_rst_in |=> wiper_q[0] == $past(preset_q[0][0]))
        else $error("Wiper zero not recalled from preset zero.");
    a_guard_refuse: assert property (@(posedge clock_in)
        disable iff (sys_rst_in) pre_try && !guard_q |-> !pre_we)
        else $error("Preset written while guarded.");
    a_guard_allow: assert property (@(posedge clock_in)
        disable iff (sys_rst_in) pre_try && guard_q |-> pre_we)
        else $error("Preset write refused while unguarded.");
    a_addr_miss: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        byte_end && phase_q == dpot_pkg::ST_ADDR && !addr_hit
        |=> !sda_oe_out && phase_q == dpot_pkg::ST_IDLE)
        else $error("Answered a foreign address.");
    a_drain_only: assert property (@(posedge clock_in)
        ##1 sda_out_out == 1'b0)
        else $error("Data line driven high.");
    a_clock_paced: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        !evt.scl_rise && !evt.scl_fall && !evt.start && !evt.stop
        |=> $stable(cnt_q))
        else $error("Bit count moved without a clock edge.");
    a_tap_onehot: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        ##1 taps_out.tap0 == onehot($past(wiper_q[0])))
        else $error("Tap zero does not follow its wiper.");
    a_recall_copy: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        wip_we && phase_q == dpot_pkg::ST_INSTR && shreg_q[0] == 1'b1
        |=> wiper_q[1] == $past(preset_q[1][shreg_q[3:2]]))
        else $error("Recall did not copy the preset.");
    a_step_up: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        wip_we && phase_q == dpot_pkg::ST_WDATA &&
        op_q == `DP_OP_INCDEC && shreg_q[7] && !ch_q &&
        wiper_q[0] != `DP_WIPER_MAX
        |=> wiper_q[0] == $past(wiper_q[0]) + 6'h01)
        else $error("Increment did not step by one.");
    a_step_sat: assert property (@(posedge clock_in)
        disable iff (sys_rst_in)
        wip_we && op_q == `DP_OP_INCDEC &&
        phase_q == dpot_pkg::ST_WDATA && !shreg_q[7] &&
        wiper_q[ch_q] == `DP_WIPER_MIN
        |=> wiper_q[ch_q] == `DP_WIPER_MIN)
        else $error("Decrement wrapped below tap zero.");
endmodule

// >>> serial_line_sense.sv
// Synchronises the serial clock and data pins and finds line events.
`timescale 1ns/1ps
module serial_line_sense (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output dpot_pkg::bus_evt_t evt_out
);
    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    logic scl_m_q; // First stage, read only by the second.
    logic sda_m_q; // First stage, read only by the second.
    logic scl_s_q; // Settled clock level.
    logic sda_s_q; // Settled data level.
    logic scl_p_q; // Clock level one cycle older.
    logic sda_p_q; // Data level one cycle older.

    // Two flops per pin, then one more for edge detection.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            scl_m_q <= 1'b1;
            sda_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_in;
            sda_m_q <= sda_in;
            scl_s_q <= scl_m_q;
            sda_s_q <= sda_m_q;
            scl_p_q <= scl_s_q;
            sda_p_q <= sda_s_q;
        end
    end

    // ------------------------------------------------------------------
    // Event flops
    // ------------------------------------------------------------------
    // Data moving while the clock is high frames a transfer.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            evt_out <= '{start: 1'b0, stop: 1'b0, scl_rise: 1'b0,
                         scl_fall: 1'b0, sda: 1'b1};
        end else begin
            evt_out.start <= scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
            evt_out.stop <= scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
            evt_out.scl_rise <= scl_s_q & ~scl_p_q;
            evt_out.scl_fall <= ~scl_s_q & scl_p_q;
            evt_out.sda <= sda_s_q;
        end
    end
endmodule

// >>> serial_master_model.sv
// Behavioural two-wire bus master that drives the potentiometer's pins.
`timescale 1ns/1ps
module serial_master_model (
    output logic scl_out,
    output logic sda_oe_out,
    input wire logic sda_in
);
    // --------------------------------------------------------------
    // Bus timing
    // --------------------------------------------------------------
    // Half of the 125 ns link period; the clock stands high between frames.
    localparam realtime HALF = 62.5;

    // Both lines start released, so the pull-up holds them high.
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end

    // --------------------------------------------------------------
    // Framing and bit tasks
    // --------------------------------------------------------------
    // Start, or repeated start: data falls while the clock is high.
    task automatic start_cond();
        sda_oe_out = 1'b0;
        #(HALF);
        scl_out = 1'b1;
        #(HALF);
        sda_oe_out = 1'b1;
        #(HALF);
        scl_out = 1'b0;
    endtask

    // Stop: data rises while the clock is high, then the clock stays idle.
    task automatic stop_cond();
        sda_oe_out = 1'b1;
        #(HALF);
        scl_out = 1'b1;
        #(HALF);
        sda_oe_out = 1'b0;
        #(HALF);
    endtask

    // One clock pulse; data changes mid-low and is sampled mid-high.
    task automatic clk_bit(input logic b, output logic r);
        #(HALF / 2);
        sda_oe_out = ~b;
        #(HALF / 2);
        scl_out = 1'b1;
        #(HALF / 2);
        r = sda_in;
        #(HALF / 2);
        scl_out = 1'b0;
    endtask

    // Sends one byte MSB first; ack is high when the device pulled low.
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
        end
        clk_bit(1'b1, r);
        ack = ~r;
    endtask

    // Reads one byte, then acks it when mack is high.
    task automatic rd_byte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, d[i]);
        end
        clk_bit(~mack, r);
    endtask
endmodule

// >>> tb.sv
// Self-checking testbench of the dual potentiometer serial control block.
`timescale 1ns/1ps
`include "dpot_defines.svh"
module tb;
    // --------------------------------------------------------------
    // Signals
    // --------------------------------------------------------------
    logic clock_in, sys_rst_in, scl, m_oe, guard_low, sda_out, sda_oe;
    logic [3:0] straps; // Address strap inputs.
    wire sda_line; // Resolved data wire with pull-up.
    wire guard_pin; // Write guard pin, open when not pulled low.
    dpot_pkg::wiper_taps_t taps;
    int n_errors, checks, cyc;
    logic [2:0] acks;
    logic [7:0] rd_val;
    logic [5:0] w, x, y;
    logic [1:0] s;
    logic up;

    // Wired-AND of both open-drain drivers; an open guard reads high.
    assign sda_line = ~(sda_oe | m_oe);
    assign guard_pin = guard_low ? 1'b0 : 1'bz;
    pullup (guard_pin);

    dual_digipot_serial_control i_dut (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .scl_in(scl),
        .sda_in(sda_line), .sda_out_out(sda_out), .sda_oe_out(sda_oe),
        .addr_strap_in(straps), .write_guard_n_in(guard_pin),
        .taps_out(taps));

    serial_master_model i_master (
        .scl_out(scl), .sda_oe_out(m_oe), .sda_in(sda_line));

    // --------------------------------------------------------------
    // Clock and timeout
    // --------------------------------------------------------------
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    // Cuts a hang short well after the expected run of about 23k cycles.
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 80000) begin
            n_errors++;
            close_out();
        end
    end

    // --------------------------------------------------------------
    // Expectation functions and checking
    // --------------------------------------------------------------
    // One-hot tap word for a wiper value.
    function automatic logic [63:0] exp_tap(input logic [5:0] v);
        return 64'h1 << v;
    endfunction

    // Wiper after n saturating steps.
    function automatic logic [5:0] step(input logic [5:0] v,
                                       input logic dir, input int n);
        for (int i = 0; i < n; i++) begin
            if (dir && v != 6'h3F) v = v + 6'h01;
            if (!dir && v != 6'h00) v = v - 6'h01;
        end
        return v;
    endfunction

    // Tap word of one channel.
    function automatic logic [63:0] tap_of(input logic ch);
        return ch ? taps.tap1 : taps.tap0;
    endfunction

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                         input string what);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // Transfer tasks
    // --------------------------------------------------------------
    // Address, instruction, then nd copies of one data byte.
    task automatic op(input logic [3:0] adr, input logic [3:0] code,
                      input logic [1:0] slot, input logic ch,
                      input logic [7:0] dat, input int nd,
                      output logic [2:0] a);
        logic k;
        a = 3'b000;
        i_master.start_cond();
        i_master.wr_byte({`DP_SLAVE_ID, adr}, k);
        a[0] = k;
        i_master.wr_byte({code, slot, 1'b0, ch}, k);
        a[1] = k;
        for (int i = 0; i < nd; i++) begin
            i_master.wr_byte(dat, k);
            a[2] = k;
        end
        i_master.stop_cond();
    endtask

    // Reads one byte back with a read instruction and a closing NACK.
    task automatic rd(input logic [3:0] code, input logic [1:0] slot,
                      input logic ch, output logic [7:0] d);
        logic k;
        i_master.start_cond();
        i_master.wr_byte({`DP_SLAVE_ID, straps}, k);
        i_master.wr_byte({code, slot, 1'b0, ch}, k);
        i_master.rd_byte(1'b0, d);
        check({63'h0, sda_out}, 64'h0, "data level");
        i_master.stop_cond();
    endtask

    // Changes bench-driven inputs just after a rising edge.
    task automatic tick();
        @(posedge clock_in);
        #1;
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        sys_rst_in = 1'b1;
        straps = 4'h0;
        guard_low = 1'b0;
        void'($urandom(32'h7D22));
        repeat (10) tick();
        sys_rst_in = 1'b0;
        repeat (6) tick();
        check(taps.tap0, exp_tap(`DP_PRESET_INIT), "recall 0");
        check(taps.tap1, exp_tap(`DP_PRESET_INIT), "recall 1");
        $display("test power-up recall done");
        // Random wipers under random straps, a wrong address among them.
        for (int k = 0; k < 6; k++) begin
            tick();
            straps = 4'($urandom);
            w = 6'($urandom);
            op(straps, `DP_OP_WR_WIPER, 2'h0, k[0], {2'($urandom), w}, 1,
               acks);
            check({61'h0, acks}, 64'h7, "acks");
            check(tap_of(k[0]), exp_tap(w), "wiper tap");
            rd(`DP_OP_RD_WIPER, 2'h0, k[0], rd_val);
            check({56'h0, rd_val}, {58'h0, w}, "wiper read");
            op(~straps, `DP_OP_WR_WIPER, 2'h0, k[0], 8'h00, 1, acks);
            check({63'h0, acks[0]}, 64'h0, "foreign addr");
            check(tap_of(k[0]), exp_tap(w), "foreign held");
        end
        $display("test wiper access done");
        // Presets with the guard pin left open.
        for (int k = 0; k < 4; k++) begin
            s = 2'(k);
            x = 6'($urandom);
            y = ~x;
            op(straps, `DP_OP_WR_PRESET, s, k[1], {2'b00, y}, 1, acks);
            rd(`DP_OP_RD_PRESET, s, k[1], rd_val);
            check({56'h0, rd_val}, {58'h0, y}, "preset");
            op(straps, `DP_OP_WR_WIPER, 2'h0, k[1], {2'b00, x}, 1, acks);
            op(straps, `DP_OP_STORE, s, k[1], 8'h00, 0, acks);
            check({61'h0, acks}, 64'h3, "store acks");
            op(straps, `DP_OP_WR_WIPER, 2'h0, k[1], {2'b00, y}, 1, acks);
            op(straps, `DP_OP_RECALL, s, k[1], 8'h00, 0, acks);
            check(tap_of(k[1]), exp_tap(x), "recall");
        end
        $display("test preset transfer done");
        // Guard low: preset writes refused, wiper writes accepted.
        tick();
        guard_low = 1'b1;
        op(straps, `DP_OP_WR_PRESET, 2'h3, 1'b1, {2'b00, y}, 1, acks);
        check({63'h0, acks[2]}, 64'h0, "guard write");
        op(straps, `DP_OP_STORE, 2'h3, 1'b1, 8'h00, 0, acks);
        check({63'h0, acks[1]}, 64'h0, "guard store");
        rd(`DP_OP_RD_PRESET, 2'h3, 1'b1, rd_val);
        check({56'h0, rd_val}, {58'h0, x}, "guard kept");
        op(straps, `DP_OP_WR_WIPER, 2'h0, 1'b1, 8'h2A, 1, acks);
        check(taps.tap1, exp_tap(6'h2A), "guard wiper");
        tick();
        guard_low = 1'b0;
        $display("test write guard done");
        // Stepping, with both end stops among the cases.
        for (int k = 0; k < 6; k++) begin
            w = (k == 0) ? 6'h3E : (k == 1) ? 6'h01 : 6'($urandom);
            up = (k == 0) ? 1'b1 : (k == 1) ? 1'b0 : 1'($urandom);
            op(straps, `DP_OP_WR_WIPER, 2'h0, k[0], {2'b00, w}, 1, acks);
            op(straps, `DP_OP_INCDEC, 2'h0, k[0], {up, 7'h00}, 3, acks);
            check(tap_of(k[0]), exp_tap(step(w, up, 3)), "step");
        end
        $display("test step mode done");
        // Reset in mid-run recalls slot zero, which reset leaves alone.
        op(straps, `DP_OP_WR_PRESET, 2'h0, 1'b0, 8'h11, 1, acks);
        op(straps, `DP_OP_WR_PRESET, 2'h0, 1'b1, 8'h3C, 1, acks);
        tick();
        sys_rst_in = 1'b1;
        repeat (4) tick();
        sys_rst_in = 1'b0;
        repeat (6) tick();
        check(taps.tap0, exp_tap(6'h11), "rerecall 0");
        check(taps.tap1, exp_tap(6'h3C), "rerecall 1");
        $display("test reset recall done");
        close_out();
    end
endmodule
